// file: design/lsm_map.vh
// constants of the logic slice: mode codes, ripple operations, table sizes
// assumes inclusion by bare name from the slice and table modules
`ifndef LSM_MAP_VH
`define LSM_MAP_VH

// ----------------------------------------
// operating modes
// ----------------------------------------
`define LSM_MODE_W 2
`define LSM_MODE_LOGIC 2'h0
`define LSM_MODE_RIPPLE 2'h1
`define LSM_MODE_RAM 2'h2
`define LSM_MODE_ROM 2'h3
`define LSM_MODE_RST 2'h0

// ----------------------------------------
// ripple operations
// ----------------------------------------
`define LSM_OP_W 3
`define LSM_OP_ADD 3'h0
`define LSM_OP_SUB 3'h1
`define LSM_OP_ADDSUB 3'h2
`define LSM_OP_UP 3'h3
`define LSM_OP_DOWN 3'h4
`define LSM_OP_MULT 3'h5

// ----------------------------------------
// table geometry and reset values
// ----------------------------------------
`define LSM_TBL_ADDR_W 4
`define LSM_TBL_DEPTH 16
`define LSM_DATA_W 2
`define LSM_TBL_RST 16'h0000
`define LSM_CNT_RST 2'h0

`endif

// file: design/lsm_table16.v
// one 16x1 table of the slice: lookup, fixed table or memory bit
// assumes config load and writes come from logic on core_clk
`timescale 1ns/1ps
`include "lsm_map.vh"

module lsm_table16 #(
	parameter ADDR_W = `LSM_TBL_ADDR_W,
	parameter DEPTH = `LSM_TBL_DEPTH
) (
	input wire core_clk,
	input wire sys_rst,
	input wire cfgLoad,
	input wire [DEPTH-1:0] cfgTable,
	input wire wrEn,
	input wire [ADDR_W-1:0] wrAddr,
	input wire wrData,
	input wire [ADDR_W-1:0] rdAddrA,
	input wire [ADDR_W-1:0] rdAddrB,
	output wire rdDataA,
	output wire rdDataB
);

	reg [DEPTH-1:0] bits_q;

	// ----------------------------------------
	// storage: configured table, optional write
	// ----------------------------------------
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bits_q <= `LSM_TBL_RST;
		end else if (cfgLoad) begin
			bits_q <= cfgTable;
		end else if (wrEn) begin
			bits_q[wrAddr] <= wrData;
		end
	end

	// reads are combinational
	assign rdDataA = bits_q[rdAddrA];
	assign rdDataB = bits_q[rdAddrB];

endmodule

// file: design/lsm_slice.v
// one programmable logic slice: logic, ripple, memory and fixed-table modes
// assumes all inputs come from fabric logic on core_clk; config by cfgLoad
`timescale 1ns/1ps
`include "lsm_map.vh"

// Contract
// - the slice runs in exactly one of four modes, logic, ripple, RAM or ROM.
// - the ramless variant offers logic, ripple and ROM but never RAM.
// - in logic mode each table takes four inputs and gives any function of them.
// - the two tables combine into one five-input lookup function.
// - six to eight input functions are built by cascading slice outputs.
// - ripple mode adds, subtracts, adds or subtracts dynamically, counts and builds multipliers.
// - ripple mode compares A and B for greater-or-equal, not-equal, less-or-equal.
// - ripple mode outputs carry-generate and carry-propagate for chaining.
// - in RAM mode the tables form a 16 word by 2 bit memory, combinable into larger ones.
// - a dual-port 16x2 memory takes two paired slices, a single-port one takes one; the code gives both ports in one slice.
// - in a pair one slice is the read-write port and its companion a read-only port; here one slice has both, port A read-write, port B read-only.
module lsm_slice #(
	parameter HAS_RAM = 1,
	parameter ADDR_W = `LSM_TBL_ADDR_W,
	parameter DEPTH = `LSM_TBL_DEPTH,
	parameter DATA_W = `LSM_DATA_W
) (
	input wire core_clk,
	input wire sys_rst,
	input wire cfgLoad,
	input wire [`LSM_MODE_W-1:0] cfgMode,
	input wire [DEPTH-1:0] cfgTable0,
	input wire [DEPTH-1:0] cfgTable1,
	input wire [ADDR_W-1:0] lutInA,
	input wire [ADDR_W-1:0] lutInB,
	input wire lut5Sel,
	input wire cascIn0,
	input wire cascIn1,
	input wire cascSel,
	input wire [DATA_W-1:0] opA,
	input wire [DATA_W-1:0] opB,
	input wire carryIn,
	input wire [`LSM_OP_W-1:0] arithOp,
	input wire addSubDyn,
	input wire mulBit,
	input wire ramWe,
	input wire [ADDR_W-1:0] ramWrAddr,
	input wire [DATA_W-1:0] ramWrData,
	input wire [ADDR_W-1:0] ramRdAddr,
	output reg [`LSM_MODE_W-1:0] modeOut_q,
	output reg cfgReject_q,
	output reg [DATA_W-1:0] lutOut_q,
	output reg lut5Out_q,
	output reg cascOut_q,
	output reg [DATA_W-1:0] sumOut_q,
	output reg carryOut_q,
	output reg carryGen_q,
	output reg carryProp_q,
	output reg cmpGe_q,
	output reg cmpNe_q,
	output reg cmpLe_q,
	output reg [DATA_W-1:0] cntOut_q,
	output reg [DATA_W-1:0] ramRwData_q,
	output reg [DATA_W-1:0] ramRoData_q
);

	// ----------------------------------------
	// mode selection
	// ----------------------------------------
	reg [`LSM_MODE_W-1:0] mode_d;
	reg reject_d;
	wire ramOk;

	assign ramOk = (HAS_RAM != 0);

	always @* begin
		mode_d = modeOut_q;
		reject_d = cfgReject_q;
		if (cfgLoad) begin
			reject_d = 1'b0;
			case (cfgMode)
			`LSM_MODE_LOGIC: begin
				mode_d = `LSM_MODE_LOGIC;
			end
			`LSM_MODE_RIPPLE: begin
				mode_d = `LSM_MODE_RIPPLE;
			end
			`LSM_MODE_RAM: begin
				if (ramOk) begin
					mode_d = `LSM_MODE_RAM;
				end else begin
					mode_d = `LSM_MODE_LOGIC;
					reject_d = 1'b1;
				end
			end
			`LSM_MODE_ROM: begin
				mode_d = `LSM_MODE_ROM;
			end
			default: begin
				mode_d = `LSM_MODE_RST;
			end
			endcase
		end
	end

	wire isLogic;
	wire isRipple;
	wire isRam;
	wire isRom;

	assign isLogic = (modeOut_q == `LSM_MODE_LOGIC);
	assign isRipple = (modeOut_q == `LSM_MODE_RIPPLE);
	assign isRam = (modeOut_q == `LSM_MODE_RAM) && ramOk;
	assign isRom = (modeOut_q == `LSM_MODE_ROM);

	// ----------------------------------------
	// two tables
	// ----------------------------------------
	wire [ADDR_W-1:0] addrA;
	wire [ADDR_W-1:0] addrB;
	wire [DATA_W-1:0] datA;
	wire [DATA_W-1:0] datB;
	wire wrEn;

	// port A: read-write port, port B: read-only companion port
	assign addrA = isRam ? ramWrAddr : lutInA;
	assign addrB = isRam ? ramRdAddr : lutInB;
	// fixed tables and lookups never write
	assign wrEn = isRam && ramWe && !cfgLoad;

	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi = gi + 1) begin : gTbl
			lsm_table16 #(
				.ADDR_W(ADDR_W),
				.DEPTH(DEPTH)
			) uTbl (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.cfgLoad(cfgLoad),
				.cfgTable(gi == 0 ? cfgTable0 : cfgTable1),
				.wrEn(wrEn),
				.wrAddr(ramWrAddr),
				.wrData(ramWrData[gi]),
				.rdAddrA(addrA),
				.rdAddrB(addrB),
				.rdDataA(datA[gi]),
				.rdDataB(datB[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// logic and fixed-table outputs
	// ----------------------------------------
	reg [DATA_W-1:0] lut_d;
	reg five_input_table_d;
	reg casc_d;

	always @* begin
		lut_d = lutOut_q;
		five_input_table_d = lut5Out_q;
		casc_d = cascOut_q;
		if (isLogic || isRom) begin
			lut_d = {datB[1], datA[0]};
			five_input_table_d = lut5Sel ? datA[1] : datA[0];
			casc_d = cascSel ? cascIn1 : cascIn0;
		end
	end

	// ----------------------------------------
	// ripple arithmetic
	// ----------------------------------------
	reg [DATA_W-1:0] bEff;
	reg cinEff;
	reg [DATA_W:0] sum;
	reg [DATA_W-1:0] cnt_d;
	wire [DATA_W-1:0] gBit;
	wire [DATA_W-1:0] pBit;

	always @* begin
		bEff = opB;
		cinEff = carryIn;
		cnt_d = cntOut_q;
		case (arithOp)
		`LSM_OP_ADD: begin
			bEff = opB;
		end
		`LSM_OP_SUB: begin
			bEff = ~opB;
		end
		`LSM_OP_ADDSUB: begin
			bEff = addSubDyn ? ~opB : opB;
		end
		`LSM_OP_MULT: begin
			bEff = opB & {DATA_W{mulBit}};
		end
		default: begin
			bEff = opB;
		end
		endcase
		sum = {1'b0, opA} + {1'b0, bEff} + {{DATA_W{1'b0}}, cinEff};
		if (isRipple && arithOp == `LSM_OP_UP) begin
			cnt_d = cntOut_q + {{(DATA_W-1){1'b0}}, carryIn};
		end else if (isRipple && arithOp == `LSM_OP_DOWN) begin
			cnt_d = cntOut_q - {{(DATA_W-1){1'b0}}, carryIn};
		end
	end

	assign gBit = opA & bEff;
	assign pBit = opA ^ bEff;

	// ----------------------------------------
	// carry terms for chaining
	// ----------------------------------------
	wire [DATA_W:0] genChain;
	wire [DATA_W:0] propChain;

	assign genChain[0] = 1'b0;
	assign propChain[0] = 1'b1;

	genvar ci;
	generate
		for (ci = 0; ci < DATA_W; ci = ci + 1) begin : gCarry
			assign genChain[ci+1] = gBit[ci] |
				(pBit[ci] & genChain[ci]);
			assign propChain[ci+1] = pBit[ci] & propChain[ci];
		end
	endgenerate

	// ----------------------------------------
	// ripple result next values
	// ----------------------------------------
	reg [DATA_W-1:0] sum_d;
	reg carry_d;
	reg gen_d;
	reg prop_d;
	reg ge_d;
	reg ne_d;
	reg le_d;

	always @* begin
		sum_d = sumOut_q;
		carry_d = carryOut_q;
		gen_d = carryGen_q;
		prop_d = carryProp_q;
		ge_d = cmpGe_q;
		ne_d = cmpNe_q;
		le_d = cmpLe_q;
		if (isRipple) begin
			sum_d = sum[DATA_W-1:0];
			carry_d = sum[DATA_W];
			gen_d = genChain[DATA_W];
			prop_d = propChain[DATA_W];
			ge_d = (opA >= opB);
			ne_d = (opA != opB);
			le_d = (opA <= opB);
		end
	end

	// ----------------------------------------
	// memory outputs
	// ----------------------------------------
	reg [DATA_W-1:0] rw_d;
	reg [DATA_W-1:0] ro_d;

	always @* begin
		rw_d = ramRwData_q;
		ro_d = ramRoData_q;
		if (isRam) begin
			rw_d = datA;
			ro_d = datB;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeOut_q <= `LSM_MODE_RST;
			cfgReject_q <= 1'b0;
			lutOut_q <= {DATA_W{1'b0}};
			lut5Out_q <= 1'b0;
			cascOut_q <= 1'b0;
			sumOut_q <= {DATA_W{1'b0}};
			carryOut_q <= 1'b0;
			carryGen_q <= 1'b0;
			carryProp_q <= 1'b0;
			cmpGe_q <= 1'b0;
			cmpNe_q <= 1'b0;
			cmpLe_q <= 1'b0;
			cntOut_q <= `LSM_CNT_RST;
			ramRwData_q <= {DATA_W{1'b0}};
			ramRoData_q <= {DATA_W{1'b0}};
		end else begin
			modeOut_q <= mode_d;
			cfgReject_q <= reject_d;
			lutOut_q <= lut_d;
			lut5Out_q <= five_input_table_d;
			cascOut_q <= casc_d;
			cntOut_q <= cnt_d;
			ramRwData_q <= rw_d;
			ramRoData_q <= ro_d;
			sumOut_q <= sum_d;
			carryOut_q <= carry_d;
			carryGen_q <= gen_d;
			carryProp_q <= prop_d;
			cmpGe_q <= ge_d;
			cmpNe_q <= ne_d;
			cmpLe_q <= le_d;
		end
	end

endmodule

// file: bench/lsm_slice_sva.sv
// checker of the logic slice outputs against its inputs
// assumes binding onto every lsm_slice instance, one clock domain
`timescale 1ns/1ps
`include "lsm_map.vh"

module lsm_slice_sva #(
	parameter HAS_RAM = 1
) (
	input wire core_clk,
	input wire sys_rst,
	input wire cfgLoad,
	input wire [1:0] cfgMode,
	input wire [15:0] cfgTable0,
	input wire [15:0] cfgTable1,
	input wire [3:0] lutInA,
	input wire [3:0] lutInB,
	input wire lut5Sel,
	input wire cascIn0,
	input wire cascIn1,
	input wire cascSel,
	input wire [1:0] opA,
	input wire [1:0] opB,
	input wire carryIn,
	input wire [2:0] arithOp,
	input wire ramWe,
	input wire [3:0] ramWrAddr,
	input wire [1:0] ramWrData,
	input wire [3:0] ramRdAddr,
	input wire [1:0] modeOut_q,
	input wire cfgReject_q,
	input wire [1:0] lutOut_q,
	input wire lut5Out_q,
	input wire cascOut_q,
	input wire [1:0] sumOut_q,
	input wire carryOut_q,
	input wire carryGen_q,
	input wire carryProp_q,
	input wire cmpGe_q,
	input wire cmpNe_q,
	input wire cmpLe_q,
	input wire [1:0] ramRwData_q,
	input wire [1:0] ramRoData_q
);
	// ----------------------------------------
	// shadow tables and mode terms
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	reg [15:0] tbl0_q;
	reg [15:0] tbl1_q;
	wire look = (modeOut_q == `LSM_MODE_LOGIC ||
		modeOut_q == `LSM_MODE_ROM) && !cfgLoad;
	wire rip = modeOut_q == `LSM_MODE_RIPPLE && !cfgLoad;
	wire addOp = rip && arithOp == `LSM_OP_ADD;
	wire noRam = cfgMode == `LSM_MODE_RAM && HAS_RAM == 0;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tbl0_q <= `LSM_TBL_RST;
			tbl1_q <= `LSM_TBL_RST;
		end else if (cfgLoad) begin
			tbl0_q <= cfgTable0;
			tbl1_q <= cfgTable1;
		end
	end
	sequence s_wr;
		modeOut_q == `LSM_MODE_RAM && ramWe && !cfgLoad
		##1 !cfgLoad && $stable(ramWrAddr);
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_mode_load: assert property (cfgLoad |=> cfgReject_q == $past(noRam) &&
		modeOut_q == ($past(noRam) ? `LSM_MODE_LOGIC : $past(cfgMode)))
		else $error("mode after load wrong");
	a_table_read: assert property (look |=> lutOut_q ==
		{tbl1_q[$past(lutInB)], tbl0_q[$past(lutInA)]})
		else $error("table lookup wrong");
	a_five_input: assert property (look |=> lut5Out_q == ($past(lut5Sel) ?
		tbl1_q[$past(lutInA)] : tbl0_q[$past(lutInA)]))
		else $error("five input lookup wrong");
	a_cascade_mux: assert property (look |=> cascOut_q ==
		($past(cascSel) ? $past(cascIn1) : $past(cascIn0)))
		else $error("cascade output wrong");
	a_add_sum: assert property (addOp |=> {carryOut_q, sumOut_q} ==
		$past(opA) + $past(opB) + $past(carryIn))
		else $error("sum wrong");
	a_compare_flags: assert property (rip |=>
		cmpGe_q == ($past(opA) >= $past(opB)) &&
		cmpNe_q == ($past(opA) != $past(opB)) &&
		cmpLe_q == ($past(opA) <= $past(opB)))
		else $error("compare flags wrong");
	a_carry_terms: assert property (addOp |=>
		carryGen_q == ($past(opA) + $past(opB) > 3) &&
		carryProp_q == (($past(opA) ^ $past(opB)) == 2'h3))
		else $error("carry terms wrong");
	a_ram_rw: assert property (s_wr |=> ramRwData_q == $past(ramWrData, 2))
		else $error("read-write port wrong");
	a_ram_ro: assert property (s_wr ##0 ramRdAddr == ramWrAddr |=>
		ramRoData_q == $past(ramWrData, 2))
		else $error("read-only port wrong");
endmodule

bind lsm_slice lsm_slice_sva #(.HAS_RAM(HAS_RAM)) sliceChk (.*);

// file: bench/lsm_neighbour.sv
// neighbouring slices that feed the cascade inputs of the slice
// assumes the bench sets the wanted levels; outputs move after core_clk
`timescale 1ns/1ps

module lsm_neighbour (
	input wire core_clk,
	input wire [1:0] nbLevel,
	output reg cascIn0,
	output reg cascIn1
);
	// ----------------------------------------
	// registered outputs, as a real slice gives
	// ----------------------------------------
	initial {cascIn1, cascIn0} = 2'h0;
	always @(posedge core_clk) begin
		{cascIn1, cascIn0} <= nbLevel;
	end
endmodule

// file: bench/testbench.sv
// self-checking bench of the logic slice, full and ramless cells
// assumes the slice checker is bound from its own file
`timescale 1ns/1ps
`include "lsm_map.vh"

module testbench;
	localparam logic [15:0] T0 = 16'ha5c3;
	localparam logic [15:0] T1 = 16'h3c69;
	logic core_clk = 0, sys_rst = 1, cfgLoad = 0, lut5Sel = 0, cascSel = 0;
	logic carryIn = 0, addSubDyn = 0, mulBit = 0, ramWe = 0;
	logic [1:0] cfgMode = 0, opA = 0, opB = 0, ramWrData = 0, nbLevel = 0;
	logic [15:0] cfgTable0 = 0, cfgTable1 = 0;
	logic [3:0] lutInA = 0, lutInB = 0, ramWrAddr = 0, ramRdAddr = 0;
	logic [2:0] arithOp = 0;
	wire cascIn0, cascIn1, cfgReject_q, lut5Out_q, cascOut_q, carryOut_q;
	wire carryGen_q, carryProp_q, cmpGe_q, cmpNe_q, cmpLe_q, rej2;
	wire [1:0] modeOut_q, lutOut_q, sumOut_q, cntOut_q, mode2;
	wire [1:0] ramRwData_q, ramRoData_q;
	int fail_count = 0, total_checks = 0;
	lsm_slice DUT (.*);
	lsm_slice #(.HAS_RAM(0)) DUT2 (.*, .modeOut_q(mode2), .cfgReject_q(rej2),
		.lutOut_q(), .lut5Out_q(), .cascOut_q(), .sumOut_q(), .carryOut_q(),
		.carryGen_q(), .carryProp_q(), .cmpGe_q(), .cmpNe_q(), .cmpLe_q(),
		.cntOut_q(), .ramRwData_q(), .ramRoData_q());
	lsm_neighbour nb (.*);
	initial forever #5 core_clk = ~core_clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task tick(input int n = 1);
		repeat (n) @(negedge core_clk);
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task load(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b);
		cfgLoad = 1;
		cfgMode = m;
		cfgTable0 = a;
		cfgTable1 = b;
		tick();
		cfgLoad = 0;
		chk(modeOut_q, m);
		chk(cfgReject_q, 1'b0);
		chk(mode2, m == `LSM_MODE_RAM ? `LSM_MODE_LOGIC : m);
		chk(rej2, m == `LSM_MODE_RAM);
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_logic();
		load(`LSM_MODE_LOGIC, T0, T1);
		for (int i = 0; i < 16; i++) begin
			lutInA = 4'(i);
			lutInB = 4'(15 - i);
			lut5Sel = i[0];
			tick();
			chk(lutOut_q, {T1[15 - i], T0[i]});
			chk(lut5Out_q, i[0] ? T1[i] : T0[i]);
		end
		for (int k = 0; k < 8; k++) begin
			nbLevel = 2'(k);
			cascSel = k[2];
			tick(2);
			chk(cascOut_q, k[2] ? k[1] : k[0]);
		end
		$display("logic and cascade done");
	endtask
	task t_ripple();
		int a, b;
		load(`LSM_MODE_RIPPLE, 16'h0000, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			a = i / 4;
			b = i % 4;
			opA = 2'(a);
			opB = 2'(b);
			arithOp = `LSM_OP_ADD;
			carryIn = 0;
			tick();
			chk({carryOut_q, sumOut_q}, 8'(a + b));
			chk({cmpGe_q, cmpNe_q, cmpLe_q}, {a >= b, a != b, a <= b});
			chk(carryGen_q, a + b > 3);
			chk(carryProp_q, (a ^ b) == 3);
			arithOp = `LSM_OP_SUB;
			carryIn = 1;
			tick();
			chk({carryOut_q, sumOut_q}, 8'(a + 4 - b));
			arithOp = `LSM_OP_ADDSUB;
			addSubDyn = i[0];
			carryIn = i[0];
			tick();
			chk({carryOut_q, sumOut_q}, 8'(i[0] ? a + 4 - b : a + b));
			arithOp = `LSM_OP_MULT;
			mulBit = i[1];
			carryIn = 0;
			tick();
			chk({carryOut_q, sumOut_q}, 8'(i[1] ? a + b : a));
		end
		arithOp = `LSM_OP_UP;
		carryIn = 1;
		for (int k = 1; k < 6; k++) begin
			tick();
			chk(cntOut_q, 8'(k % 4));
		end
		arithOp = `LSM_OP_DOWN;
		for (int k = 1; k < 4; k++) begin
			tick();
			chk(cntOut_q, 8'((5 - k) % 4));
		end
		carryIn = 0;
		$display("ripple done");
	endtask
	task t_ram();
		load(`LSM_MODE_RAM, 16'h0000, 16'h0000);
		ramWe = 1;
		ramWrAddr = 4'h3;
		ramWrData = 2'h2;
		tick();
		ramWrAddr = 4'hf;
		ramWrData = 2'h1;
		tick();
		ramWe = 0;
		ramWrAddr = 4'h3;
		ramRdAddr = 4'hf;
		tick();
		chk(ramRwData_q, 2'h2);
		chk(ramRoData_q, 2'h1);
		ramWe = 1;
		ramWrAddr = 4'h5;
		ramWrData = 2'h3;
		ramRdAddr = 4'h5;
		tick();
		ramWe = 0;
		chk(ramRoData_q, 2'h0);
		tick();
		chk(ramRoData_q, 2'h3);
		$display("ram done");
	endtask
	task t_rom();
		load(`LSM_MODE_ROM, 16'h8421, 16'h1248);
		ramWe = 1;
		ramWrAddr = 4'h2;
		ramWrData = 2'h3;
		lutInA = 4'h2;
		lutInB = 4'h2;
		tick();
		ramWe = 0;
		tick();
		chk(lutOut_q, 2'h0);
		lutInA = 4'h0;
		lutInB = 4'h3;
		tick();
		chk(lutOut_q, 2'h3);
		$display("rom done");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		tick(8);
		sys_rst = 0;
		t_logic();
		t_ripple();
		t_ram();
		t_rom();
		wrap_up();
	end
	initial begin
		#20000;
		fail_count++;
		wrap_up();
	end
endmodule
